// File: logic/jtag_nvm_programmer.sv
`timescale 1ns/1ps
module jtag_nvm_programmer
  import jtag_prog_pkg::*;
#(
  parameter int TCK_HALF = TCK_HALF_CYCLES,
  parameter int POLL_LIMIT = 256,
  parameter int WAIT_CYCLES = 20000,
  parameter int WORD_INDEX_BITS = 7,
  parameter logic [3:0] IR_CORE_RESET = 4'h1,
  parameter logic [3:0] IR_PROGRAMMING_ENABLE_INSTR = 4'h2,
  parameter logic [3:0] IR_COMMAND_MODE = 4'h3,
  parameter logic [3:0] IR_PAGE_LOAD = 4'h4,
  parameter logic [3:0] IR_PAGE_READ = 4'h5,
  parameter logic [14:0] W_ERASE_START = 15'h0001,
  parameter logic [14:0] W_ERASE_GO = 15'h0002,
  parameter logic [14:0] W_ERASE_POLL = 15'h0003
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Link pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);

  scan_if sc ();

  seq_state_type qstate;
  op_type op_r;
  op_type req_op;
  step_type cur;
  logic wait_r;
  logic [3:0] idx;
  logic [15:0] poll_cnt;
  logic [31:0] timer;
  logic [7:0] arg;
  logic [14:0] raw;
  logic [31:0] result;
  logic [15:0] last_word;
  logic [31:0] status;
  logic prog_mode;
  logic page_load;
  logic page_read;
  logic done_flag;
  logic err;
  logic timeout;
  logic req;
  logic accept;
  logic scan_done;
  logic poll_miss;
  logic poll_last;
  logic timer_end;

  function automatic step_type ir_step(input logic [3:0] code);
    ir_step = '{kind: K_IR, len: 5'(IR_LEN), data: {12'h000, code}, idle: 5'h00};
  endfunction : ir_step

  function automatic step_type dr_step(input logic [4:0] n, input logic [15:0] d, input logic [4:0] gap);
    dr_step = '{kind: K_DR, len: n, data: d, idle: gap};
  endfunction : dr_step

  function automatic step_type word_step(input logic [14:0] w);
    word_step = dr_step(5'h0F, {1'b0, w}, 5'h00);
  endfunction : word_step

  function automatic step_type poll_step(input logic [14:0] w);
    poll_step = '{kind: K_POLL, len: 5'h0F, data: {1'b0, w}, idle: 5'h00};
  endfunction : poll_step

  function automatic logic op_legal(input op_type op, input logic pm, input logic pl, input logic pr);
    case (op)
      OP_ENTER, OP_LEAVE: op_legal = 1'b1;
      OP_PAGE_BYTE: op_legal = pm && (pl || pr);
      default: op_legal = pm;
    endcase
  endfunction : op_legal

  function automatic step_type step_at(input op_type op, input logic [3:0] i, input logic [7:0] a,
                                       input logic [14:0] r);
    step_type s;
    logic [15:0] pa;
    s = '{kind: K_END, len: 5'h00, data: 16'h0000, idle: 5'h00};
    pa = {1'b0, r} & ~16'((17'h1_0000 >> (16 - WORD_INDEX_BITS)) - 17'h0_0001);
    if (i == 4'h0) begin
      s = ir_step(IR_COMMAND_MODE);
    end
    case (op)
      OP_ENTER: begin
        case (i)
          4'h0: s = ir_step(IR_CORE_RESET);
          4'h1: s = dr_step(5'h01, 16'h0001, 5'h00);
          4'h2: s = ir_step(IR_PROGRAMMING_ENABLE_INSTR);
          4'h3: s = dr_step(5'h10, ENABLE_KEY, 5'h00);
          default: s.kind = K_END;
        endcase
      end
      OP_LEAVE: begin
        case (i)
          4'h0: s = ir_step(IR_COMMAND_MODE);
          4'h1: s = word_step(W_NOP);
          4'h2: s = word_step(W_COMMIT_HOLD);
          4'h3: s = ir_step(IR_PROGRAMMING_ENABLE_INSTR);
          4'h4: s = dr_step(5'h10, DISABLE_KEY, 5'h00);
          4'h5: s = ir_step(IR_CORE_RESET);
          4'h6: s = dr_step(5'h01, 16'h0000, 5'h00);
          default: s.kind = K_END;
        endcase
      end
      OP_NOP: begin
        if (i == 4'h1) s = word_step(W_NOP);
        if (i == 4'h2) s = word_step(W_COMMIT_HOLD);
      end
      OP_ERASE: begin
        if (i == 4'h1 || i == 4'h3) s = word_step(W_ERASE_START);
        if (i == 4'h2) s = word_step(W_ERASE_GO);
        if (i == 4'h4) s = poll_step(W_ERASE_POLL);
      end
      OP_LOCK_WRITE, OP_FUSE_LOW_WRITE: begin
        case (i)
          4'h0: s = ir_step(IR_COMMAND_MODE);
          4'h1: s = word_step(op == OP_LOCK_WRITE ? W_LOCK_ENTER : W_FUSE_WR_ENTER);
          4'h2: s = word_step(op == OP_LOCK_WRITE ? {HI_DATA_LOW, LOCK_PAD, a[5:0]} : {HI_DATA_LOW, a});
          4'h3: s = word_step(W_COMMIT_HOLD);
          4'h4: s = word_step(W_COMMIT_GO);
          4'h5: s = word_step(W_COMMIT_HOLD);
          4'h6: s = poll_step(W_COMMIT_HOLD);
          default: s.kind = K_END;
        endcase
      end
      OP_READ_EXT, OP_READ_HIGH, OP_READ_LOW, OP_READ_LOCK, OP_READ_ALL: begin
        case (i)
          4'h0: s = ir_step(IR_COMMAND_MODE);
          4'h1: s = word_step(W_FUSE_RD_ENTER);
          4'h2: begin
            case (op)
              OP_READ_HIGH: s = word_step(W_HIGH_A);
              OP_READ_LOW: s = word_step(W_LOW_A);
              OP_READ_LOCK: s = word_step(W_LOCK_A);
              default: s = word_step(W_EXT_A);
            endcase
          end
          4'h3: begin
            case (op)
              OP_READ_EXT: s = word_step(W_EXT_B);
              OP_READ_HIGH: s = word_step(W_HIGH_B);
              OP_READ_LOW: s = word_step(W_LOW_B);
              OP_READ_LOCK: s = word_step(W_LOCK_B);
              default: s = word_step(W_HIGH_A);
            endcase
          end
          4'h4: if (op == OP_READ_ALL) s = word_step(W_LOW_A);
          4'h5: if (op == OP_READ_ALL) s = word_step(W_LOCK_A);
          4'h6: if (op == OP_READ_ALL) s = word_step(W_LOCK_B);
          default: s.kind = K_END;
        endcase
      end
      OP_SIGNATURE, OP_CALIB: begin
        if (i == 4'h1) s = word_step(W_SIG_ENTER);
        if (i == 4'h2) s = word_step({HI_ADDR_LOW, a});
        if (i == 4'h3) s = word_step(op == OP_SIGNATURE ? W_LOW_A : W_LOCK_A);
        if (i == 4'h4) s = word_step(op == OP_SIGNATURE ? W_LOW_B : W_LOCK_B);
      end
      OP_RAW: begin
        if (i == 4'h1) s = word_step(r);
      end
      OP_PAGE_ADDR: begin
        if (i == 4'h1) s = word_step({HI_ADDR_EXT, 8'h00});
        if (i == 4'h2) s = word_step({HI_ADDR_HIGH, pa[15:8]});
        if (i == 4'h3) s = word_step({HI_ADDR_LOW, pa[7:0]});
      end
      OP_PAGE_LOAD: begin
        if (i == 4'h0) s = ir_step(IR_PAGE_LOAD);
      end
      OP_PAGE_READ: begin
        if (i == 4'h0) s = ir_step(IR_PAGE_READ);
      end
      OP_PAGE_BYTE: begin
        s.kind = K_END;
        if (i == 4'h0) s = dr_step(5'h08, {8'h00, a}, 5'(PAGE_GAP_TCK));
      end
      default: s.kind = K_END;
    endcase
    step_at = s;
  endfunction : step_at

  jtag_scan_engine #(
    .TCK_HALF(TCK_HALF)
  ) u_engine (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .sc(sc.engine)
  );

  assign sc.tdo = tdo;
  assign tck = sc.tck;
  assign tms = sc.tms;
  assign tdi = sc.tdi;

  assign cur = step_at(op_r, idx, arg, raw);
  assign req = wr && (addr == REG_CTRL || addr == REG_PAGE);
  assign accept = req && qstate == Q_IDLE && op_legal(req_op, prog_mode, page_load, page_read);
  assign scan_done = qstate == Q_SCAN && sc.done;
  assign poll_miss = scan_done && cur.kind == K_POLL && !sc.tdo_word[DONE_BIT];
  assign poll_last = poll_cnt == 16'(POLL_LIMIT - 1);
  assign timer_end = qstate == Q_TIMER && timer == 32'(WAIT_CYCLES - 1);

  always_comb begin
    req_op = op_type'(wdata[CTRL_OP_LSB +: CTRL_OP_W]);
    if (addr == REG_PAGE) begin
      req_op = OP_PAGE_BYTE;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[ST_BUSY] = qstate != Q_IDLE;
    status[ST_PROG] = prog_mode;
    status[ST_PLOAD] = page_load;
    status[ST_PREAD] = page_read;
    status[ST_DONE] = done_flag;
    status[ST_ERR] = err;
    status[ST_TIMEOUT] = timeout;
  end

  // Argument registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arg <= 8'h00;
      raw <= 15'h0000;
    end else if (ce && wr && qstate == Q_IDLE) begin
      if (addr == REG_ARG || addr == REG_PAGE) begin
        arg <= wdata[7:0];
      end
      if (addr == REG_RAW) begin
        raw <= wdata[14:0];
      end
    end
  end

  // Step sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      qstate <= Q_IDLE;
      op_r <= OP_NOP;
      wait_r <= 1'b0;
      idx <= 4'h0;
      poll_cnt <= 16'h0000;
      timer <= 32'h0000_0000;
      sc.start <= 1'b0;
      sc.is_ir <= 1'b0;
      sc.len <= 5'h00;
      sc.data <= 16'h0000;
      sc.idle <= 5'h00;
    end else if (ce) begin
      sc.start <= 1'b0;
      case (qstate)
        Q_IDLE: begin
          if (accept) begin
            op_r <= req_op;
            wait_r <= (addr == REG_CTRL) && wdata[CTRL_WAIT_BIT];
            idx <= 4'h0;
            poll_cnt <= 16'h0000;
            qstate <= Q_ISSUE;
          end
        end
        Q_ISSUE: begin
          if (cur.kind == K_END) begin
            qstate <= Q_IDLE;
          end else if (cur.kind == K_POLL && wait_r) begin
            timer <= 32'h0000_0000;
            qstate <= Q_TIMER;
          end else begin
            sc.start <= 1'b1;
            sc.is_ir <= cur.kind == K_IR;
            sc.len <= cur.len;
            sc.data <= cur.data;
            sc.idle <= cur.idle;
            qstate <= Q_SCAN;
          end
        end
        Q_SCAN: begin
          if (poll_miss) begin
            poll_cnt <= poll_cnt + 16'h0001;
            qstate <= poll_last ? Q_IDLE : Q_ISSUE;
          end else if (scan_done) begin
            idx <= idx + 4'h1;
            qstate <= Q_ISSUE;
          end
        end
        Q_TIMER: begin
          timer <= timer + 32'h0000_0001;
          if (timer_end) begin
            idx <= idx + 4'h1;
            qstate <= Q_ISSUE;
          end
        end
        default: qstate <= Q_IDLE;
      endcase
    end
  end

  // Results, flags and mode tracking
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prog_mode <= 1'b0;
      page_load <= 1'b0;
      page_read <= 1'b0;
      done_flag <= 1'b0;
      err <= 1'b0;
      timeout <= 1'b0;
      result <= 32'h0000_0000;
      last_word <= 16'h0000;
    end else if (ce) begin
      if (req && !accept) begin
        err <= 1'b1;
      end else if (accept) begin
        err <= 1'b0;
        timeout <= 1'b0;
        done_flag <= 1'b0;
      end
      if (scan_done) begin
        last_word <= sc.tdo_word;
        if (cur.kind == K_DR) begin
          result <= {result[23:0], sc.tdo_word[7:0]};
        end
        if (cur.kind == K_POLL) begin
          done_flag <= sc.tdo_word[DONE_BIT];
        end
      end
      if (poll_miss && poll_last) begin
        timeout <= 1'b1;
      end
      // timed wait stands for the poll
      if (timer_end) begin
        done_flag <= 1'b1;
      end
      if (qstate == Q_ISSUE && cur.kind == K_END) begin
        case (op_r)
          OP_ENTER: prog_mode <= 1'b1;
          OP_LEAVE: prog_mode <= 1'b0;
          OP_PAGE_LOAD: page_load <= 1'b1;
          OP_PAGE_READ: page_read <= 1'b1;
          OP_PAGE_BYTE: prog_mode <= prog_mode;
          default: begin
            page_load <= 1'b0;
            page_read <= 1'b0;
          end
        endcase
        if (op_r == OP_LEAVE || op_r == OP_PAGE_LOAD) begin
          page_read <= 1'b0;
        end
        if (op_r == OP_LEAVE || op_r == OP_PAGE_READ) begin
          page_load <= 1'b0;
        end
      end
    end
  end

  // Register read port
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        case (addr)
          REG_CTRL: rdata <= status;
          REG_ARG: rdata <= {24'h00_0000, arg};
          REG_RAW: rdata <= {17'h0_0000, raw};
          REG_RESULT: rdata <= result;
          REG_LAST: rdata <= {16'h0000, last_word};
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : jtag_nvm_programmer

// File: logic/jtag_prog_pkg.sv
package jtag_prog_pkg;

  // Link timing
  localparam int IR_LEN = 4;
  localparam int TCK_HALF_CYCLES = 4;
  localparam int PAGE_GAP_TCK = 11;
  localparam int DONE_BIT = 9;

  // Enable keys
  localparam logic [15:0] ENABLE_KEY = 16'hA370;
  localparam logic [15:0] DISABLE_KEY = 16'h0000;

  // Whole command words
  localparam logic [14:0] W_LOCK_ENTER = 15'h2320;
  localparam logic [14:0] W_FUSE_WR_ENTER = 15'h2340;
  localparam logic [14:0] W_FUSE_RD_ENTER = 15'h2304;
  localparam logic [14:0] W_SIG_ENTER = 15'h2308;
  localparam logic [14:0] W_NOP = 15'h2300;
  localparam logic [14:0] W_COMMIT_HOLD = 15'h3300;
  localparam logic [14:0] W_COMMIT_GO = 15'h3100;
  localparam logic [14:0] W_EXT_A = 15'h3A00;
  localparam logic [14:0] W_EXT_B = 15'h3B00;
  localparam logic [14:0] W_HIGH_A = 15'h3E00;
  localparam logic [14:0] W_HIGH_B = 15'h3F00;
  localparam logic [14:0] W_LOW_A = 15'h3200;
  localparam logic [14:0] W_LOW_B = 15'h3300;
  localparam logic [14:0] W_LOCK_A = 15'h3600;
  localparam logic [14:0] W_LOCK_B = 15'h3700;

  // Upper command bits of words carrying a byte
  localparam logic [6:0] HI_ADDR_EXT = 7'h0B;
  localparam logic [6:0] HI_ADDR_HIGH = 7'h07;
  localparam logic [6:0] HI_ADDR_LOW = 7'h03;
  localparam logic [6:0] HI_DATA_LOW = 7'h13;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_RAW = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_LAST = 8'h10;
  localparam logic [7:0] REG_PAGE = 8'h14;

  // Control and status fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 5;
  localparam int CTRL_WAIT_BIT = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_PROG = 1;
  localparam int ST_PLOAD = 2;
  localparam int ST_PREAD = 3;
  localparam int ST_DONE = 4;
  localparam int ST_ERR = 5;
  localparam int ST_TIMEOUT = 6;

  typedef enum logic [1:0] {K_IR, K_DR, K_POLL, K_END} step_kind_type;

  typedef struct packed {
    step_kind_type kind;
    logic [4:0] len;
    logic [15:0] data;
    logic [4:0] idle;
  } step_type;

  typedef enum logic [4:0] {
    OP_ENTER = 5'h00,
    OP_LEAVE = 5'h01,
    OP_NOP = 5'h02,
    OP_ERASE = 5'h03,
    OP_LOCK_WRITE = 5'h04,
    OP_FUSE_LOW_WRITE = 5'h05,
    OP_READ_EXT = 5'h06,
    OP_READ_HIGH = 5'h07,
    OP_READ_LOW = 5'h08,
    OP_READ_LOCK = 5'h09,
    OP_READ_ALL = 5'h0A,
    OP_SIGNATURE = 5'h0B,
    OP_CALIB = 5'h0C,
    OP_RAW = 5'h0D,
    OP_PAGE_ADDR = 5'h0E,
    OP_PAGE_LOAD = 5'h0F,
    OP_PAGE_READ = 5'h10,
    OP_PAGE_BYTE = 5'h11
  } op_type;

  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_ISSUE = 2'b01,
    Q_SCAN = 2'b11,
    Q_TIMER = 2'b10
  } seq_state_type;

  typedef enum logic [2:0] {
    E_RESET = 3'b000,
    E_IDLE = 3'b001,
    E_HEAD = 3'b011,
    E_SHIFT = 3'b010,
    E_TAIL = 3'b110,
    E_RTI = 3'b111
  } engine_state_type;

endpackage : jtag_prog_pkg

// File: logic/scan_if.sv
`timescale 1ns/1ps
interface scan_if;
  logic start;
  logic is_ir;
  logic [4:0] len;
  logic [15:0] data;
  logic [4:0] idle;
  logic done;
  logic [15:0] tdo_word;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport engine (input start, is_ir, len, data, idle, tdo, output done, tdo_word, tck, tms, tdi);
  modport seq (output start, is_ir, len, data, idle, tdo, input done, tdo_word, tck, tms, tdi);
endinterface : scan_if

// File: logic/jtag_scan_engine.sv
`timescale 1ns/1ps
module jtag_scan_engine
  import jtag_prog_pkg::*;
#(
  parameter int TCK_HALF = TCK_HALF_CYCLES
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Scan request and pins
  scan_if.engine sc
);

  engine_state_type state;
  logic [7:0] half;
  logic tdo_meta;
  logic tdo_sync;
  logic fall;
  logic pend;
  logic is_ir;
  logic [4:0] cnt;
  logic [4:0] len;
  logic [4:0] idle;
  logic [15:0] data;
  logic [15:0] word;

  assign fall = sc.tck && (half == 8'(TCK_HALF - 1));

  // Pin synchroniser
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tdo_meta <= 1'b0;
      tdo_sync <= 1'b0;
    end else if (ce) begin
      tdo_meta <= sc.tdo;
      tdo_sync <= tdo_meta;
    end
  end

  // Link clock divider, parked low when idle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      half <= 8'h00;
      sc.tck <= 1'b0;
    end else if (ce) begin
      if (state == E_IDLE && !sc.tck) begin
        half <= 8'h00;
      end else if (half == 8'(TCK_HALF - 1)) begin
        half <= 8'h00;
        sc.tck <= !sc.tck;
      end else begin
        half <= half + 8'h01;
      end
    end
  end

  // Request kept while the walk from reset runs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
    end else if (ce) begin
      if (state == E_IDLE) begin
        pend <= 1'b0;
      end else if (sc.start) begin
        pend <= 1'b1;
      end
    end
  end

  // TAP walk, pins change at the falling edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= E_RESET;
      cnt <= 5'h00;
      is_ir <= 1'b0;
      len <= 5'h00;
      idle <= 5'h00;
      data <= 16'h0000;
      word <= 16'h0000;
      sc.tms <= 1'b1;
      sc.tdi <= 1'b0;
      sc.done <= 1'b0;
      sc.tdo_word <= 16'h0000;
    end else if (ce) begin
      sc.done <= 1'b0;
      if (state == E_IDLE) begin
        if (sc.start || pend) begin
          is_ir <= sc.is_ir;
          len <= sc.len;
          idle <= sc.idle;
          data <= sc.data;
          word <= 16'h0000;
          cnt <= 5'h00;
          state <= E_HEAD;
        end
      end else if (fall) begin
        case (state)
          E_RESET: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h04) begin
              sc.tms <= 1'b0;
            end
            if (cnt == 5'h05) begin
              cnt <= 5'h00;
              // Park tms high for the next scan
              sc.tms <= 1'b1;
              state <= E_IDLE;
            end
          end
          E_HEAD: begin
            if (cnt == (is_ir ? 5'h03 : 5'h02)) begin
              cnt <= 5'h00;
              sc.tms <= (len == 5'h01);
              sc.tdi <= data[0];
              state <= E_SHIFT;
            end else begin
              cnt <= cnt + 5'h01;
              sc.tms <= (cnt == 5'h00) && is_ir;
            end
          end
          E_SHIFT: begin
            word[cnt[3:0]] <= tdo_sync;
            if (cnt == len - 5'h01) begin
              sc.tms <= 1'b1;
              sc.tdi <= 1'b0;
              state <= E_TAIL;
            end else begin
              cnt <= cnt + 5'h01;
              sc.tdi <= data[4'(cnt + 5'h01)];
              sc.tms <= (cnt + 5'h02 == len);
            end
          end
          E_TAIL: begin
            sc.tms <= 1'b0;
            cnt <= 5'h00;
            state <= E_RTI;
          end
          E_RTI: begin
            if (cnt == idle) begin
              sc.tms <= 1'b1;
              sc.done <= 1'b1;
              sc.tdo_word <= word;
              state <= E_IDLE;
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
          default: begin
            state <= E_IDLE;
          end
        endcase
      end
    end
  end

endmodule : jtag_scan_engine

// File: dv/jtag_nvm_programmer_monitor.sv
`timescale 1ns/1ps
module jtag_nvm_programmer_monitor
  import jtag_prog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle_zero: assert property (ce && $past(ce) && !$past(rd) |-> rdata == 32'h0000_0000)
    else $error("rdata not zero outside a read");
  a_unmapped_zero: assert property (rd && ce && addr == 8'hFC |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_tms_at_fall: assert property ($changed(tms) |-> $fell(tck))
    else $error("tms moved away from a tck fall");
  a_tdi_at_fall: assert property ($changed(tdi) |-> $fell(tck))
    else $error("tdi moved away from a tck fall");
  a_tck_high_len: assert property ($rose(tck) |-> tck [*4] ##1 !tck)
    else $error("tck high phase wrong length");
  a_tck_low_len: assert property ($fell(tck) |-> !tck [*4])
    else $error("tck low phase too short");
  a_enter_busy: assert property ((wr && addr == REG_CTRL && wdata[4:0] == OP_ENTER) ##1
    (rd && addr == REG_CTRL) |=> rdata[ST_BUSY]) else $error("enter did not raise busy");
  a_arg_readback: assert property ((wr && addr == REG_ARG) ##1 (rd && addr == REG_ARG)
    |=> rdata[7:0] == $past(wdata[7:0], 2)) else $error("argument readback wrong");
endmodule : jtag_nvm_programmer_monitor
bind jtag_nvm_programmer jtag_nvm_programmer_monitor i_jtag_nvm_programmer_monitor (.core_clk(core_clk),
  .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tck(tck), .tms(tms), .tdi(tdi));

// File: dv/jtag_device_model.sv
`timescale 1ns/1ps
module jtag_device_model
  import jtag_prog_pkg::*;
(
  // Link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // Test control
  input wire logic stall
);
  logic [2:0] st = 3'd7;
  logic [15:0] sr = 16'h0000;
  logic [3:0] ir = 4'h0;
  logic is_ir = 1'b0;
  logic prog = 1'b0;
  logic [14:0] last = 15'h0000;
  logic [7:0] mem [256];
  logic [7:0] ptr = 8'h00;
  logic hb = 1'b0;
  logic fresh = 1'b0;
  initial tdo = 1'b0;
  always @(posedge tck) begin
    case (st)
      3'd0: st <= tms ? 3'd1 : 3'd0;
      3'd1: begin
        st <= tms ? 3'd2 : 3'd3;
        is_ir <= 1'b0;
      end
      3'd2: begin
        st <= tms ? 3'd7 : 3'd3;
        is_ir <= 1'b1;
      end
      3'd3: begin
        sr <= is_ir ? 16'h0001 : {6'h00, ~stall, 1'b0, 1'b0, last[14:8]};
        if (!is_ir && ir == 4'h5 && prog) begin
          sr <= {8'h00, mem[{ptr[6:0], hb}]};
          ptr <= ptr + {7'h00, hb};
          hb <= !hb;
        end
        st <= tms ? 3'd5 : 3'd4;
      end
      3'd4: begin
        sr <= {tdi, sr[15:1]};
        st <= tms ? 3'd5 : 3'd4;
      end
      3'd5: begin
        st <= tms ? 3'd6 : 3'd4;
      end
      3'd6: begin
        if (is_ir) begin
          ir <= sr[15:12];
          ptr <= 8'h00;
          hb <= 1'b0;
          fresh <= 1'b1;
        end else if (ir == 4'h2) prog <= (sr == ENABLE_KEY);
        else if (ir == 4'h3 && prog) last <= sr[15:1];
        else if (ir == 4'h4 && prog) begin
          mem[{ptr[6:0] + {6'h00, !hb && !fresh}, hb}] <= sr[15:8];
          ptr <= ptr + {7'h00, !hb && !fresh};
          hb <= !hb;
          fresh <= 1'b0;
        end
        st <= tms ? 3'd1 : 3'd0;
      end
      default: st <= tms ? 3'd7 : 3'd0;
    endcase
  end
  // Released line toggles
  always @(negedge tck) tdo <= (st == 3'd4) ? sr[0] : ~tdo;
endmodule : jtag_device_model

// File: dv/jtag_nvm_programming_engine_tb.sv
`timescale 1ns/1ps
module jtag_nvm_programming_engine_tb;
  import jtag_prog_pkg::*;
  logic core_clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0, stall = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, v;
  logic tck, tms, tdi, tdo;
  int n_errors = 0, n_tests = 0;
  logic [12:0] rows [6] = '{{OP_READ_EXT, 8'h3A}, {OP_READ_HIGH, 8'h3E}, {OP_READ_LOW, 8'h32},
    {OP_SIGNATURE, 8'h32}, {OP_CALIB, 8'h36}, {OP_READ_LOCK, 8'h36}};
  always #12.5 core_clk = ~core_clk;
  jtag_nvm_programmer #(.POLL_LIMIT(4), .WAIT_CYCLES(50)) i_jtag_nvm_programmer (.core_clk(core_clk), .nrst(nrst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jtag_device_model i_jtag_device_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .stall(stall));
  task end_of_test;
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task wrreg(input logic [7:0] a, input logic [31:0] d);
    rd <= 0;
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
  endtask : wrreg
  task rdreg(input logic [7:0] a, output logic [31:0] q);
    wr <= 0;
    rd <= 1;
    addr <= a;
    @(posedge core_clk);
    rd <= 0;
    #1 q = rdata;
  endtask : rdreg
  task check(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      n_errors++;
    end
  endtask : check
  task run(input logic [31:0] d, input logic [7:0] a = REG_CTRL);
    int i;
    wrreg(a, d);
    for (i = 0; i < 4000; i++) begin
      rdreg(REG_CTRL, v);
      if (v[ST_BUSY] === 1'b0) break;
    end
    if (i == 4000) begin
      n_errors++;
      end_of_test();
    end
  endtask : run
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    rdreg(8'hFC, v);
    check("unmapped", 0, v);
    run(OP_READ_EXT);
    check("err before enter", 1, v[ST_ERR]);
    run(OP_ENTER);
    check("prog mode", 1, v[ST_PROG]);
    for (int r = 0; r < 6; r++) begin
      run(rows[r][12:8]);
      rdreg(REG_RESULT, v);
      check("result byte", rows[r][7:0], v[7:0]);
    end
    rdreg(REG_LAST, v);
    check("last word", 32'h0000_0236, v);
    run(OP_READ_ALL);
    rdreg(REG_RESULT, v);
    check("read all order", 24'h3A3E32, v[31:8]);
    wrreg(REG_ARG, 32'h0000_0015);
    rdreg(REG_ARG, v);
    check("arg readback", 32'h0000_0015, v);
    run(OP_LOCK_WRITE);
    check("lock done", 1, v[ST_DONE]);
    run(OP_FUSE_LOW_WRITE);
    check("fuse done", 1, v[ST_DONE]);
    run(OP_ERASE);
    check("erase done", 1, v[ST_DONE]);
    stall <= 1;
    run(OP_LOCK_WRITE);
    check("poll timeout", 1, v[ST_TIMEOUT]);
    run((32'h1 << CTRL_WAIT_BIT) | OP_ERASE);
    check("timed erase", 1, v[ST_DONE]);
    stall <= 0;
    wrreg(REG_RAW, 32'h0000_3A00);
    run(OP_RAW);
    run(OP_PAGE_ADDR);
    rdreg(REG_RESULT, v);
    check("page address words", 24'h3A0B07, v[23:0]);
    run(OP_PAGE_LOAD);
    check("page load", 1, v[ST_PLOAD]);
    for (int b = 0; b < 3; b++) run(32'h0000_00A5 + b, REG_PAGE);
    run(OP_PAGE_READ);
    for (int b = 0; b < 3; b++) run(32'h0000_0000, REG_PAGE);
    rdreg(REG_RESULT, v);
    check("page readback", 24'hA5A6A7, v[23:0]);
    run(OP_NOP);
    check("nop cancels", 0, v[ST_PREAD:ST_PLOAD]);
    run(OP_LEAVE);
    check("left prog", 0, v[ST_PROG]);
    end_of_test();
  end
endmodule : jtag_nvm_programming_engine_tb
